// ==== rtl/rsi_unit.sv ====
// reset cause tracking, interrupt flags, mask, global enable and vectoring
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rsi_unit #(
    parameter int PORT_W = 8,
    parameter int PC_W = 10
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic pin_reset_in,
    input wire logic wdt_timeout_in,
    input wire logic timer_overflow_in,
    input wire logic [PORT_W-1:0] port6_pins_in,
    input wire logic [PORT_W-1:0] port6_is_output_in,
    input wire logic ext_irq_sel_in,
    input wire logic enable_irq_instr_in,
    input wire logic disable_irq_instr_in,
    input wire logic return_from_irq_instr_in,
    input wire logic sleep_instr_in,
    input wire logic watchdog_clear_instr_in,
    input wire logic soft_irq_instr_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic core_reset_out,
    output logic core_sleeping_out,
    output logic irq_req_out,
    output logic pc_load_out,
    output logic [PC_W-1:0] pc_vector_out,
    output logic wake_continue_out,
    output logic time_out_flag_out,
    output logic power_down_flag_out,
    output logic global_irq_en_out
);
    logic [2:0] irq_status_reg_q;
    logic [2:0] irq_mask_reg_q;
    logic wake_en_q;
    logic gie_q;
    logic to_q;
    logic pd_q;
    logic timer_q;
    logic ext_q;
    logic [7:0] rdata_q;
    logic rst_out_q;
    logic irq_q;
    logic pc_load_q;
    logic [PC_W-1:0] pc_vec_q;
    logic wake_cont_q;
    rsi_pkg::rsi_state_t state_q;
    rsi_pkg::rsi_state_t state_d;
    logic [PORT_W-1:0] watch;
    logic change;
    logic port6_read;
    logic timer_fall;
    logic ext_fall;
    logic [2:0] set_ev;
    logic [2:0] clr_wr;
    logic sleeping;
    logic change_wake;
    logic pending;
    logic any_reset;
    logic sleep_q;

    assign sleeping = (state_q == rsi_pkg::RSI_ST_SLEEP);
    assign any_reset = pin_reset_in | wdt_timeout_in;
    assign port6_read = reg_rd_in && (reg_addr_in == rsi_pkg::RSI_OFS_PORT6);

    // outputs and the external bit are not watched for change
    always_comb
    begin
        watch = ~port6_is_output_in;
        watch[0] = ~port6_is_output_in[0] & ~ext_irq_sel_in;
    end

    rsi_edge_det #(
        .WIDTH(PORT_W)
    ) u_change (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .pins_in(port6_pins_in),
        .watch_in(watch),
        .refresh_in(port6_read),
        .change_out(change)
    );

    // falling-edge capture; history starts low so leaving reset never looks like a fall
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            timer_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else
        begin
            timer_q <= timer_overflow_in;
            ext_q <= port6_pins_in[0];
        end
    end

    assign timer_fall = timer_q & ~timer_overflow_in;
    assign ext_fall = ext_irq_sel_in & ext_q & ~port6_pins_in[0];
    // change flag only records while its source is enabled
    always_comb
    begin
        set_ev = 3'h0;
        set_ev[rsi_pkg::RSI_SRC_TIMER] = timer_fall;
        set_ev[rsi_pkg::RSI_SRC_EXT] = ext_fall;
        set_ev[rsi_pkg::RSI_SRC_CHANGE] = change & irq_mask_reg_q[rsi_pkg::RSI_SRC_CHANGE];
        clr_wr = 3'h0;
        if (reg_wr_in && reg_addr_in == rsi_pkg::RSI_OFS_STATUS)
            clr_wr = ~reg_wdata_in[2:0];
    end

    // status flags: writing 0 clears, an event in the same cycle wins
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_status_reg_q <= rsi_pkg::RSI_STATUS_RST;
        else if (any_reset)
            irq_status_reg_q <= rsi_pkg::RSI_STATUS_RST;
        else
            irq_status_reg_q <= (irq_status_reg_q & ~clr_wr) | set_ev;
    end

    // mask, wake enable
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_mask_reg_q <= rsi_pkg::RSI_MASK_RST;
            wake_en_q <= 1'b0;
        end
        else if (any_reset)
        begin
            irq_mask_reg_q <= rsi_pkg::RSI_MASK_RST;
            wake_en_q <= 1'b0;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == rsi_pkg::RSI_OFS_MASK)
                irq_mask_reg_q <= reg_wdata_in[2:0];
            if (reg_addr_in == rsi_pkg::RSI_OFS_WAKE)
                wake_en_q <= reg_wdata_in[0];
        end
    end

    // global enable
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            gie_q <= 1'b0;
        else if (any_reset)
            gie_q <= 1'b0;
        else if (enable_irq_instr_in || return_from_irq_instr_in)
            gie_q <= 1'b1;
        else if (disable_irq_instr_in || pc_load_q)
            gie_q <= 1'b0;
    end

    assign pending = |(irq_status_reg_q & irq_mask_reg_q);
    assign change_wake = sleeping && wake_en_q && change;

    // run state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rsi_pkg::RSI_ST_RUN:
            begin
                if (sleep_instr_in)
                    state_d = rsi_pkg::RSI_ST_SLEEP;
            end
            rsi_pkg::RSI_ST_SLEEP:
            begin
                if (any_reset)
                    state_d = rsi_pkg::RSI_ST_RUN;
                else if (change_wake)
                    state_d = rsi_pkg::RSI_ST_WAKE;
            end
            rsi_pkg::RSI_ST_WAKE:
                state_d = rsi_pkg::RSI_ST_RUN;
            default:
                state_d = rsi_pkg::RSI_ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_q <= rsi_pkg::RSI_ST_RUN;
        else
            state_q <= state_d;
    end

    // registered copy of the sleep state so the output leaves a flip-flop
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sleep_q <= 1'b0;
        else
            sleep_q <= (state_d == rsi_pkg::RSI_ST_SLEEP);
    end

    // time-out and power-down flags; the reset cause and sleep state pick the result
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            to_q <= rsi_pkg::RSI_TO_POR;
            pd_q <= rsi_pkg::RSI_PD_POR;
        end
        else if (wdt_timeout_in)
        begin
            to_q <= 1'b0;
            if (sleeping)
                pd_q <= 1'b0;
        end
        else if (pin_reset_in)
        begin
            if (sleeping)
            begin
                to_q <= 1'b1;
                pd_q <= 1'b0;
            end
        end
        else if (change_wake)
        begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end
        else if (watchdog_clear_instr_in)
        begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end
        else if (sleep_instr_in && !sleeping)
        begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end
    end

    // core reset request, interrupt request, vectoring
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_out_q <= 1'b1;
            irq_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_vec_q <= '0;
            wake_cont_q <= 1'b0;
        end
        else
        begin
            rst_out_q <= any_reset;
            irq_q <= gie_q & pending;
            pc_load_q <= 1'b0;
            wake_cont_q <= 1'b0;
            if (any_reset)
                pc_vec_q <= '0;
            else if (soft_irq_instr_in && gie_q)
            begin
                pc_load_q <= 1'b1;
                pc_vec_q <= PC_W'(rsi_pkg::RSI_VEC_SWI);
            end
            else if (state_q == rsi_pkg::RSI_ST_WAKE && !gie_q)
                wake_cont_q <= 1'b1;
            else if (gie_q && pending && !pc_load_q && !sleeping)
            begin
                pc_load_q <= 1'b1;
                pc_vec_q <= PC_W'(rsi_pkg::RSI_VEC_IRQ);
            end
        end
    end

    // read data one cycle after the strobe; a read of status sees flags gated by mask
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_q <= 8'h00;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                rsi_pkg::RSI_OFS_STATUS: rdata_q <= {5'h00, irq_status_reg_q & irq_mask_reg_q};
                rsi_pkg::RSI_OFS_MASK: rdata_q <= {5'h00, irq_mask_reg_q};
                rsi_pkg::RSI_OFS_PORT6: rdata_q <= port6_pins_in[7:0];
                rsi_pkg::RSI_OFS_WAKE: rdata_q <= {7'h00, wake_en_q};
                rsi_pkg::RSI_OFS_TP: rdata_q <= {6'h00, to_q, pd_q};
                default: rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata_out = rdata_q;
    assign core_reset_out = rst_out_q;
    assign core_sleeping_out = sleep_q;
    assign irq_req_out = irq_q;
    assign pc_load_out = pc_load_q;
    assign pc_vector_out = pc_vec_q;
    assign wake_continue_out = wake_cont_q;
    assign time_out_flag_out = to_q;
    assign power_down_flag_out = pd_q;
    assign global_irq_en_out = gie_q;
endmodule
`default_nettype wire

// ==== rtl/rsi_pkg.sv ====
// package: constants for the reset status and interrupt unit
package rsi_pkg;
    localparam int RSI_NUM_SRC = 3;
    localparam int RSI_PORT_W = 8;
    localparam int RSI_PC_W = 10;
    // source bit positions in status and mask
    localparam int RSI_SRC_TIMER = 0;
    localparam int RSI_SRC_CHANGE = 1;
    localparam int RSI_SRC_EXT = 2;
    // vectors
    localparam logic [9:0] RSI_VEC_IRQ = 10'h008;
    localparam logic [9:0] RSI_VEC_SWI = 10'h001;
    // register offsets on the plain port
    localparam logic [3:0] RSI_OFS_STATUS = 4'h0;
    localparam logic [3:0] RSI_OFS_MASK = 4'h1;
    localparam logic [3:0] RSI_OFS_PORT6 = 4'h2;
    localparam logic [3:0] RSI_OFS_WAKE = 4'h3;
    localparam logic [3:0] RSI_OFS_TP = 4'h4;
    // reset values
    localparam logic [2:0] RSI_STATUS_RST = 3'h0;
    localparam logic [2:0] RSI_MASK_RST = 3'h0;
    localparam logic RSI_TO_POR = 1'b1;
    localparam logic RSI_PD_POR = 1'b1;
    // field positions in the time-out/power-down register
    localparam int RSI_TP_TO_BIT = 1;
    localparam int RSI_TP_PD_BIT = 0;
    // core run states
    typedef enum logic [1:0] {
        RSI_ST_RUN = 2'b00,
        RSI_ST_SLEEP = 2'b01,
        RSI_ST_WAKE = 2'b10
    } rsi_state_t;
endpackage

// ==== rtl/rsi_edge_det.sv ====
// per-pin change detector against a reference level refreshed by port reads
`timescale 1ns/100ps
`default_nettype none
module rsi_edge_det #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    input wire logic [WIDTH-1:0] watch_in,
    input wire logic refresh_in,
    output logic change_out
);
    logic [WIDTH-1:0] ref_q;
    logic [WIDTH-1:0] diff;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // reference follows the pin only on a port read, so a change is held until firmware reads
            always_ff @(posedge core_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    ref_q[i] <= 1'b0;
                else if (refresh_in)
                    ref_q[i] <= pins_in[i];
            end
            assign diff[i] = watch_in[i] & (pins_in[i] ^ ref_q[i]);
        end
    endgenerate

    assign change_out = |diff;
endmodule
`default_nettype wire

// ==== verification/rsi_unit_props.sv ====
// checker: port relations of the reset status and interrupt unit
`timescale 1ns/100ps
`default_nettype none
module rsi_unit_props #(
    parameter int PC_W = 10
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic pin_reset_in,
    input wire logic wdt_timeout_in,
    input wire logic enable_irq_instr_in,
    input wire logic return_from_irq_instr_in,
    input wire logic sleep_instr_in,
    input wire logic core_sleeping_out,
    input wire logic core_reset_out,
    input wire logic irq_req_out,
    input wire logic pc_load_out,
    input wire logic [PC_W-1:0] pc_vector_out,
    input wire logic time_out_flag_out,
    input wire logic power_down_flag_out,
    input wire logic global_irq_en_out
);
    // a synchronous reset clears the enable, so it is kept out of the enable checks
    wire logic rs = pin_reset_in | wdt_timeout_in;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_gie_on; enable_irq_instr_in && !rs && !pc_load_out |=> global_irq_en_out; endproperty
    a_gie_on: assert property (p_gie_on) else $error("enable not set");
    property p_return_from_irq_instr; return_from_irq_instr_in && !rs && !pc_load_out |=> global_irq_en_out; endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return left enable off");
    property p_sleep; sleep_instr_in && !rs && !core_sleeping_out |=> time_out_flag_out && !power_down_flag_out; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_wdt; wdt_timeout_in && !pin_reset_in && !core_sleeping_out && !sleep_instr_in
        |=> !time_out_flag_out && power_down_flag_out == $past(power_down_flag_out); endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog flags wrong");
    property p_pin; pin_reset_in && !wdt_timeout_in && !core_sleeping_out && !sleep_instr_in
        |=> $stable(time_out_flag_out) && $stable(power_down_flag_out); endproperty
    a_pin: assert property (p_pin) else $error("pin reset changed flags");
    property p_req; irq_req_out |-> $past(global_irq_en_out); endproperty
    a_req: assert property (p_req) else $error("request without enable");
    property p_vec; $rose(irq_req_out) && !core_sleeping_out && !$past(core_sleeping_out)
        |-> pc_load_out && pc_vector_out == rsi_pkg::RSI_VEC_IRQ; endproperty
    a_vec: assert property (p_vec) else $error("no vector load");
    property p_rst; rs |=> core_reset_out; endproperty
    a_rst: assert property (p_rst) else $error("core not reset");
endmodule
bind rsi_unit rsi_unit_props #(.PC_W(PC_W)) rsi_unit_props_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .pin_reset_in(pin_reset_in), .wdt_timeout_in(wdt_timeout_in), .enable_irq_instr_in(enable_irq_instr_in),
    .return_from_irq_instr_in(return_from_irq_instr_in), .sleep_instr_in(sleep_instr_in),
    .core_sleeping_out(core_sleeping_out), .core_reset_out(core_reset_out), .irq_req_out(irq_req_out),
    .pc_load_out(pc_load_out), .pc_vector_out(pc_vector_out), .time_out_flag_out(time_out_flag_out),
    .power_down_flag_out(power_down_flag_out), .global_irq_en_out(global_irq_en_out));
`default_nettype wire

// ==== verification/rsi_core_model.sv ====
// core model: takes vector loads and returns from the routine after a delay
`timescale 1ns/100ps
`default_nettype none
module rsi_core_model (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic pc_load_in,
    input wire logic [3:0] delay_in,
    output logic return_from_irq_instr_out,
    output logic [7:0] n_load_out
);
    logic [3:0] wait_q;
    // delay zero never returns; the flag must be cleared before the return
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_q <= 4'h0;
            return_from_irq_instr_out <= 1'b0;
            n_load_out <= 8'h00;
        end
        else
        begin
            return_from_irq_instr_out <= (wait_q == 4'h1);
            if (pc_load_in)
            begin
                wait_q <= delay_in;
                n_load_out <= n_load_out + 8'h01;
            end
            else if (wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// testbench: reset causes, flags, vectoring and wake-up
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int EN = 0, DIS = 1, SLP = 2, WDC = 3, SWI = 4, WDT = 5, PIN = 6, TMR = 7;
    localparam logic [3:0] ST = rsi_pkg::RSI_OFS_STATUS, MK = rsi_pkg::RSI_OFS_MASK;
    logic clk = 1'b0, rst_n = 1'b0, xs = 1'b0, wr = 1'b0, rd = 1'b0, crst, sl, irq, pcl, wk, t_o, pd, gie, return_from_irq_instr;
    logic [7:0] ins = 8'h00, p6 = 8'h00, p6o = 8'h00, wd = 8'h00, rdata, nld, v;
    logic [3:0] addr = 4'h0, dly = 4'h4;
    logic [9:0] vec;
    int errors = 0, n_tests = 0, seed = 73, cyc = 0, w;
    rsi_unit rsi_unit_i (.core_clk_in(clk), .rst_n_in(rst_n), .pin_reset_in(ins[PIN]),
        .wdt_timeout_in(ins[WDT]), .timer_overflow_in(ins[TMR]), .port6_pins_in(p6),
        .port6_is_output_in(p6o), .ext_irq_sel_in(xs), .enable_irq_instr_in(ins[EN]),
        .disable_irq_instr_in(ins[DIS]), .return_from_irq_instr_in(return_from_irq_instr), .sleep_instr_in(ins[SLP]),
        .watchdog_clear_instr_in(ins[WDC]), .soft_irq_instr_in(ins[SWI]), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .core_reset_out(crst), .core_sleeping_out(sl), .irq_req_out(irq), .pc_load_out(pcl),
        .pc_vector_out(vec), .wake_continue_out(wk), .time_out_flag_out(t_o),
        .power_down_flag_out(pd), .global_irq_en_out(gie));
    rsi_core_model rsi_core_model_i (.core_clk_in(clk), .rst_n_in(rst_n), .pc_load_in(pcl),
        .delay_in(dly), .return_from_irq_instr_out(return_from_irq_instr), .n_load_out(nld));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tp(input logic [1:0] e);
        chk("tp", {8'h00, t_o, pd}, {8'h00, e});
    endtask
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pls(input int i);
        @(posedge clk);
        ins[i] <= 1'b1;
        @(posedge clk);
        ins[i] <= 1'b0;
        #1;
    endtask
    // bounded wait for a vector load, or for a wake pulse
    task automatic wt(input logic on_wake);
        w = 0;
        while (((on_wake ? wk : pcl) !== 1'b1) && w < 20)
        begin
            @(posedge clk);
            #1 w++;
        end
        chk("seen", {9'h000, w < 20}, 10'h001);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 tp(2'b11);
        rdr(rsi_pkg::RSI_OFS_TP);
        chk("tp_reg", {2'b00, v}, 10'h003);
        rdr(4'hF);
        chk("unmapped", {2'b00, v}, 10'h000);
        $display("test reset done");
        wrr(MK, 8'h00);
        pls(TMR);
        @(posedge clk);
        xs <= 1'b1;
        p6[0] <= 1'b1;
        repeat (3) @(posedge clk);
        p6[0] <= 1'b0;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            w = $random(seed);
            wrr(MK, {5'h00, w[2:0]});
            rdr(ST);
            chk("status", {2'b00, v}, {7'h00, w[2:0] & 3'h5});
        end
        wrr(ST, 8'h00);
        $display("test flags done");
        wrr(MK, 8'h01);
        pls(EN);
        chk("gie", gie, 1'b1);
        pls(TMR);
        wt(1'b0);
        chk("irq", irq, 1'b1);
        chk("vec", vec, rsi_pkg::RSI_VEC_IRQ);
        wrr(ST, 8'h00);
        #1 chk("gie", gie, 1'b0);
        repeat (8) @(posedge clk);
        #1 chk("return_from_irq_instr", gie, 1'b1);
        dly <= 4'h9;
        pls(SWI);
        wt(1'b0);
        chk("vec", vec, rsi_pkg::RSI_VEC_SWI);
        repeat (14) @(posedge clk);
        pls(DIS);
        chk("gie", gie, 1'b0);
        pls(SWI);
        repeat (6) @(posedge clk);
        chk("loads", {2'b00, nld}, 10'h002);
        $display("test vectors done");
        @(posedge clk);
        p6o <= 8'h0F;
        rdr(rsi_pkg::RSI_OFS_PORT6);
        chk("port6", {2'b00, v}, {2'b00, p6});
        wrr(MK, 8'h02);
        wrr(rsi_pkg::RSI_OFS_WAKE, 8'h01);
        pls(SLP);
        tp(2'b10);
        @(posedge clk);
        p6[2] <= ~p6[2];
        repeat (6) @(posedge clk);
        #1 chk("asleep", sl, 1'b1);
        @(posedge clk);
        w = 4 + ($random(seed) & 3);
        p6[w] <= ~p6[w];
        wt(1'b1);
        tp(2'b10);
        chk("awake", sl, 1'b0);
        $display("test wake done");
        pls(WDC);
        tp(2'b11);
        pls(WDT);
        tp(2'b01);
        pls(PIN);
        chk("crst", crst, 1'b1);
        tp(2'b01);
        pls(SLP);
        pls(WDT);
        tp(2'b00);
        pls(SLP);
        pls(PIN);
        tp(2'b10);
        chk("awake", sl, 1'b0);
        rdr(rsi_pkg::RSI_OFS_PORT6);
        chk("port6", {2'b00, v}, {2'b00, p6});
        wrr(MK, 8'h02);
        wrr(rsi_pkg::RSI_OFS_WAKE, 8'h01);
        pls(EN);
        pls(SLP);
        @(posedge clk);
        w = 4 + ($random(seed) & 3);
        p6[w] <= ~p6[w];
        wt(1'b0);
        chk("vec", vec, rsi_pkg::RSI_VEC_IRQ);
        chk("cont", wk, 1'b0);
        $display("test resets done");
        report_and_stop;
    end
endmodule
`default_nettype wire
